/* File: rx_pcf_checker.sv */
/* Link checker for the receiver-to-fabric path.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module rx_pcf_checker
  import rx_pcf_pkg::*;
(
  input wire logic clk_sys_in, // Clock
  input wire logic rstn_in, // Reset
  input wire logic [NUM_CH-1:0][DATA_W-1:0] rd_data, // Head data
  input wire logic [NUM_CH-1:0][STAT_W-1:0] rd_status, // Head status
  input wire logic [NUM_CH-1:0] rd_valid, // Not empty
  input wire logic [NUM_CH-1:0] rd_ready, // Fabric ready
  input wire logic [NUM_CH-1:0] rd_tick, // Read tick
  input wire logic [NUM_CH-1:0] fabric_tick // Fabric tick
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_reset_empty: assert property ($rose(rstn_in) |-> rd_valid == '0)
    else $error("fifo not empty after reset");
  // One driver feeds every fabric read input
  a_common_tick: assert property (fabric_tick == {NUM_CH{fabric_tick[0]}})
    else $error("fabric ticks differ");
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    sequence idle_s;
      rd_valid[c] && !(rd_tick[c] && rd_ready[c]);
    endsequence
    a_idle_valid: assert property (idle_s |=> rd_valid[c])
      else $error("word lost");
    a_idle_data: assert property (idle_s |=> $stable(rd_data[c]))
      else $error("head data moved");
    a_idle_status: assert property (idle_s |=> $stable(rd_status[c]))
      else $error("head status moved");
    a_busy_hold: assert property (rd_valid[c] && !rd_ready[c] |=> rd_valid[c])
      else $error("pop without ready");
    a_notick_hold: assert property (rd_valid[c] && !rd_tick[c] |=> rd_valid[c])
      else $error("pop without tick");
    a_notick_pair: assert property (rd_valid[c] && !rd_tick[c]
      |=> $stable({rd_status[c], rd_data[c]}))
      else $error("word split");
  end
endmodule
`default_nettype wire

/* File: rx_pcf_device_end.sv */
/*
  Receiver end: one phase compensation FIFO per channel, write tick chosen
  from the channel configuration, read tick chosen automatically or taken
  from the fabric. Assumes channel clocks arrive as ticks in clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Generic FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module pcf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] wr_data_in, // Write word
  input wire logic wr_valid_in, // Write request
  output logic wr_ready_out, // Not full
  output logic [WIDTH-1:0] rd_data_out, // Head word
  output logic rd_valid_out, // Not empty
  input wire logic rd_ready_in // Pop
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_r != '0);
  assign rd_data_out = mem_r[rd_ptr_r];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_ready_in && rd_valid_out;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_data_in;
    end
  end

  // Empty after reset; equal clock rates then keep it within one word of empty
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module rx_pcf_device_end
  import rx_pcf_pkg::*;
(
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire rx_cfg_e cfg_in, // Channel configuration
  input wire logic [NUM_BLK-1:0] ident_all_in, // All four channels identical
  input wire logic [NUM_BLK-1:0] ident_pairs_in, // Channels 0-1 and 2-3 identical
  input wire logic [NUM_CH-1:0] fabric_clk_en_in, // Fabric read clock enabled
  input wire logic byte_deser_in, // Byte deserializer in use
  input wire logic [NUM_CH-1:0] tx_tick_in, // Parallel transmit clock ticks
  input wire logic [NUM_CH-1:0] rx_tick_in, // Recovered clock ticks
  input wire logic [NUM_BLK-1:0] core_tick_in, // Bonded core clock ticks
  input wire logic [NUM_CH-1:0][DATA_W-1:0] rx_data_in, // Received data
  input wire logic [NUM_CH-1:0][STAT_W-1:0] rx_status_in, // Received status
  input wire logic [NUM_CH-1:0] rx_valid_in, // Word offered
  output logic [NUM_CH-1:0] rx_ready_out, // Word taken on write tick
  rx_pcf_if.xcvr link // To fabric end
);
  logic [NUM_CH-1:0] half_r;

  // ----------------------------------------------------------------
  // Per-channel clock selection and FIFO
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int BLK = c / CH_PER_BLK;
    localparam int BASE = BLK * CH_PER_BLK;
    localparam int PAIR = BASE + (((c % CH_PER_BLK) >= PAIR_OFS) ? PAIR_OFS : 0);
    logic wr_src;
    logic wr_tick;
    logic auto_rd;
    logic fifo_wr_ready;
    logic [FIFO_W-1:0] head;

    // Bonded modes imply a rate matcher, so they write on the core clock
    always_comb begin
      case (cfg_in)
        CFG_NB_RATE_MATCH: wr_src = tx_tick_in[c];
        CFG_NB_NO_RATE_MATCH: wr_src = rx_tick_in[c];
        CFG_BONDED_X4: wr_src = core_tick_in[BLK];
        CFG_BONDED_X8: wr_src = core_tick_in[MASTER_BLK];
        default: wr_src = rx_tick_in[c];
      endcase
    end

    // Divide-by-two: pass every second source tick
    always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
        half_r[c] <= RST_HALF;
      end else if (wr_src) begin
        half_r[c] <= ~half_r[c];
      end
    end
    assign wr_tick = byte_deser_in ? (wr_src && half_r[c]) : wr_src;

    // Grouping by identity is only used when rate matched
    always_comb begin
      case (cfg_in)
        CFG_NB_RATE_MATCH: begin
          if (ident_all_in[BLK]) begin
            auto_rd = tx_tick_in[BASE];
          end else if (ident_pairs_in[BLK]) begin
            auto_rd = tx_tick_in[PAIR];
          end else begin
            auto_rd = tx_tick_in[c];
          end
        end
        CFG_NB_NO_RATE_MATCH: auto_rd = rx_tick_in[c];
        CFG_BONDED_X4: auto_rd = core_tick_in[BLK];
        CFG_BONDED_X8: auto_rd = core_tick_in[MASTER_BLK];
        default: auto_rd = rx_tick_in[c];
      endcase
    end

    // Fabric input overrides automatic choice
    assign link.rd_tick[c] = fabric_clk_en_in[c] ? link.fabric_tick[c] : auto_rd;

    pcf_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .wr_data_in({rx_status_in[c], rx_data_in[c]}),
      .wr_valid_in(rx_valid_in[c] && wr_tick),
      .wr_ready_out(fifo_wr_ready),
      .rd_data_out(head),
      .rd_valid_out(link.rd_valid[c]),
      .rd_ready_in(link.rd_ready[c] && link.rd_tick[c])
    );

    // Back-pressure reaches the receiver; word only taken on a write tick
    assign rx_ready_out[c] = fifo_wr_ready && wr_tick;
    assign link.rd_data[c] = head[DATA_W-1:0];
    assign link.rd_status[c] = head[FIFO_W-1:DATA_W];
  end
endmodule
`default_nettype wire

/* File: rx_pcf_fabric_end.sv */
/*
  Fabric end: supplies an optional common read clock and latches each
  channel's data and status on the read clock routed to that channel.
  Assumes the common clock source is 0 PPM to every FIFO write clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_pcf_fabric_end
  import rx_pcf_pkg::*;
(
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic common_tick_in, // Common read clock tick
  input wire logic [NUM_CH-1:0] accept_in, // User ready per channel
  output logic [NUM_CH-1:0][DATA_W-1:0] data_out, // Latched data
  output logic [NUM_CH-1:0][STAT_W-1:0] status_out, // Latched status
  output logic [NUM_CH-1:0] strobe_out, // One-cycle new-word pulse
  rx_pcf_if.fabric link // To receiver end
);
  // ----------------------------------------------------------------
  // Common read clock and latching
  // ----------------------------------------------------------------
  // One driver for every channel saves clock resources; user owns 0 PPM
  assign link.fabric_tick = {NUM_CH{common_tick_in}};
  assign link.rd_ready = accept_in;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic take;
    assign take = link.rd_tick[c] && link.rd_valid[c] && accept_in[c];

    always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
        data_out[c] <= '0;
        status_out[c] <= '0;
        strobe_out[c] <= 1'b0;
      end else begin
        strobe_out[c] <= take;
        if (take) begin
          data_out[c] <= link.rd_data[c];
          status_out[c] <= link.rd_status[c];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: rx_pcf_if.sv */
/*
  Link between the transceiver receiver end and the fabric end.
  Assumes both ends run on the same system clock; channel clocks are ticks.
*/
`timescale 1ns/1ps
`default_nettype none
interface rx_pcf_if;
  import rx_pcf_pkg::*;
  logic [NUM_CH-1:0][DATA_W-1:0] rd_data;
  logic [NUM_CH-1:0][STAT_W-1:0] rd_status;
  logic [NUM_CH-1:0] rd_valid;
  logic [NUM_CH-1:0] rd_ready;
  logic [NUM_CH-1:0] rd_tick;
  logic [NUM_CH-1:0] fabric_tick;

  modport xcvr (
    output rd_data, rd_status, rd_valid, rd_tick,
    input rd_ready, fabric_tick
  );
  modport fabric (
    input rd_data, rd_status, rd_valid, rd_tick,
    output rd_ready, fabric_tick
  );
endinterface
`default_nettype wire

/* File: rx_pcf_pkg.sv */
/*
  Shared constants and types for the receiver phase compensation FIFO
  read-clock selection: channel counts, data widths, FIFO depth, modes.
  Assumes one system clock; every channel clock is seen as a one-cycle tick.
*/
package rx_pcf_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_PER_BLK = 4;
  localparam int NUM_BLK = 2;
  localparam int MASTER_BLK = 0;
  localparam int PAIR_OFS = 2;
  localparam int DATA_W = 16;
  localparam int STAT_W = 2;
  localparam int FIFO_W = DATA_W + STAT_W;
  localparam int FIFO_DEPTH = 8;
  localparam logic RST_HALF = 1'b0;

  typedef enum logic [1:0] {
    CFG_NB_RATE_MATCH,
    CFG_NB_NO_RATE_MATCH,
    CFG_BONDED_X4,
    CFG_BONDED_X8
  } rx_cfg_e;
endpackage

/* File: rx_phase_comp_fifo_read_clock_select_tb.sv */
/* Testbench: both ends joined by the link, tick sources driven here.
   Assumes the package constants and a 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module rx_phase_comp_fifo_read_clock_select_tb;
  import rx_pcf_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  rx_cfg_e cfg = CFG_NB_NO_RATE_MATCH;
  logic [1:0] ia = 2'h0;
  logic [1:0] ip = 2'h0;
  logic bd = 1'b1;
  logic [NUM_CH-1:0] fen = '0;
  logic [NUM_CH-1:0] acc = '1;
  logic [NUM_CH-1:0] rval = '0;
  logic [NUM_CH-1:0] rdy;
  // Receiver ready as seen while the tick of the last pulse stood
  logic [NUM_CH-1:0] rdy_seen = '0;
  logic [NUM_CH-1:0] strobe;
  // Tick sources: tx 0-7, recovered 8-15, core 16-17, common 18
  logic [18:0] tk = '0;
  logic [NUM_CH-1:0][DATA_W-1:0] rdat = '0;
  logic [NUM_CH-1:0][DATA_W-1:0] dout;
  logic [NUM_CH-1:0][STAT_W-1:0] rsta = '0;
  logic [NUM_CH-1:0][STAT_W-1:0] sout;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  rx_pcf_if rx_pcf_if_i ();
  rx_pcf_device_end rx_pcf_device_end_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .cfg_in(cfg), .ident_all_in(ia), .ident_pairs_in(ip), .fabric_clk_en_in(fen),
    .byte_deser_in(bd), .tx_tick_in(tk[7:0]), .rx_tick_in(tk[15:8]),
    .core_tick_in(tk[17:16]), .rx_data_in(rdat), .rx_status_in(rsta),
    .rx_valid_in(rval), .rx_ready_out(rdy), .link(rx_pcf_if_i));
  rx_pcf_fabric_end rx_pcf_fabric_end_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .common_tick_in(tk[18]), .accept_in(acc), .data_out(dout), .status_out(sout),
    .strobe_out(strobe), .link(rx_pcf_if_i));
  rx_pcf_checker rx_pcf_checker_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .rd_data(rx_pcf_if_i.rd_data), .rd_status(rx_pcf_if_i.rd_status),
    .rd_valid(rx_pcf_if_i.rd_valid), .rd_ready(rx_pcf_if_i.rd_ready),
    .rd_tick(rx_pcf_if_i.rd_tick), .fabric_tick(rx_pcf_if_i.fabric_tick));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle tick on source s, optionally offering word w to channel c
  task automatic pulse(input int s, input int c, input logic v, input logic [17:0] w);
    @(posedge clk_sys_in);
    tk <= 19'h1 << s;
    rval[c] <= v;
    {rdat[c], rsta[c]} <= w;
    #1;
    rdy_seen = rdy;
    @(posedge clk_sys_in);
    tk <= '0;
    rval <= '0;
    #1;
  endtask

  task automatic mode(input rx_cfg_e m, input logic [1:0] a, input logic [1:0] p,
    input logic [7:0] f);
    @(posedge clk_sys_in);
    cfg <= m;
    ia <= a;
    ip <= p;
    fen <= f;
  endtask

  // Write on w, a wrong tick b must not pop, the right tick r must
  task automatic run(input int c, input int w, input int r, input int b);
    logic [17:0] x;
    x = 18'h2a5c1 ^ 18'(c * 18'h1357);
    pulse(w, c, 1'b1, x);
    chk(18'(rdy_seen[c]), 18'h1);
    pulse(b, c, 1'b0, x);
    chk(18'(strobe[c]), 18'h0);
    pulse(r, c, 1'b0, x);
    chk(18'(strobe[c]), 18'h1);
    chk({dout[c], sout[c]}, x);
    $display("test on channel %0d done", c);
  endtask

  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    pulse(13, 5, 1'b1, 18'h155);
    chk(18'(rdy_seen[5]), 18'h0);
    chk(18'(rx_pcf_if_i.rd_valid[5]), 18'h0);
    pulse(13, 5, 1'b1, 18'h155);
    chk(18'(rdy_seen[5]), 18'h1);
    chk(18'(rx_pcf_if_i.rd_valid[5]), 18'h1);
    @(posedge clk_sys_in);
    bd <= 1'b0;
    pulse(13, 5, 1'b0, 18'h0);
    chk({dout[5], sout[5]}, 18'h155);
    $display("test halved write clock done");
    @(posedge clk_sys_in);
    acc[0] <= 1'b0;
    for (int i = 0; i < 9; i++) pulse(8, 0, 1'b1, 18'(i + 1));
    chk(18'(rdy_seen[0]), 18'h0);
    @(posedge clk_sys_in);
    acc[0] <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      pulse(8, 0, 1'b0, 18'h0);
      chk({dout[0], sout[0]}, 18'(i + 1));
    end
    chk(18'(rx_pcf_if_i.rd_valid[0]), 18'h0);
    $display("test fill and drain done");
    mode(CFG_NB_RATE_MATCH, 2'h1, 2'h0, 8'h00);
    run(3, 3, 0, 3);
    mode(CFG_NB_RATE_MATCH, 2'h0, 2'h2, 8'h00);
    run(7, 7, 6, 4);
    mode(CFG_NB_RATE_MATCH, 2'h0, 2'h0, 8'h00);
    run(1, 1, 1, 0);
    mode(CFG_NB_NO_RATE_MATCH, 2'h0, 2'h0, 8'h00);
    run(2, 10, 10, 2);
    mode(CFG_BONDED_X4, 2'h0, 2'h0, 8'h00);
    run(6, 17, 17, 16);
    mode(CFG_BONDED_X8, 2'h0, 2'h0, 8'h00);
    run(6, 16, 16, 17);
    mode(CFG_BONDED_X8, 2'h0, 2'h0, 8'h10);
    run(4, 16, 18, 16);
    end_of_test();
  end
endmodule
`default_nettype wire
